//--- core/fdp_pkg.sv
// Constants for the floppy drive signal layer
package fdp_pkg;
    // ------------------------------------------------------------
    // Clock rate selection
    // ------------------------------------------------------------
    localparam logic CLK_SEL_24MHZ = 1'b0;
    localparam logic CLK_SEL_48MHZ = 1'b1;
    localparam logic CLK_SEL_RESET = CLK_SEL_24MHZ;

    // ------------------------------------------------------------
    // Pad configuration layout
    // ------------------------------------------------------------
    localparam int  PAD_CFG_WIDTH       = 8;
    localparam int  PAD_PULLUP_DIS_BIT  = 7;
    localparam logic [7:0] PAD_CFG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Step pulse timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ      = 10000000;
    localparam int STEP_LOW_NS     = 1000;
    localparam int STEP_HIGH_NS    = 1000;
    localparam int STEP_LOW_CYC    = (STEP_LOW_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int STEP_HIGH_CYC   = (STEP_HIGH_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int STEP_CNT_W      = 8;
    localparam int TRACK_CNT_W     = 8;

    typedef enum logic [1:0] {
        FDP_STEP_IDLE = 2'b00,
        FDP_STEP_LOW  = 2'b01,
        FDP_STEP_HIGH = 2'b10
    } fdp_step_type;
endpackage : fdp_pkg

//--- core/fdp_signal_layer.sv
// Pin-level floppy drive signal layer
`timescale 1ns/1ps
`default_nettype none
module fdp_signal_layer (
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    // Core-side controls
    input  wire logic                                clk_sel_wr,
    input  wire logic                                clk_sel_in,
    input  wire logic                                pad_cfg_wr,
    input  wire logic [fdp_pkg::PAD_CFG_WIDTH-1:0]   pad_cfg_in,
    input  wire logic                                motor_on,
    input  wire logic                                drive_select,
    input  wire logic                                side_one,
    input  wire logic                                seek_start,
    input  wire logic                                seek_outward,
    input  wire logic [fdp_pkg::TRACK_CNT_W-1:0]     seek_tracks,
    input  wire logic                                write_active,
    input  wire logic                                write_bit,
    // Core-side status
    output logic                                     clk_sel_48,
    output logic [fdp_pkg::PAD_CFG_WIDTH-1:0]        pad_config_reg,
    output logic                                     seek_busy,
    output logic                                     at_index,
    output logic                                     at_outer_track,
    output logic                                     write_protected,
    output logic                                     read_serial,
    output logic                                     disk_changed,
    // Drive-side pins (open drain: output low and enable)
    output logic                                     motor_on_drive0_n_oe,
    output logic                                     select_drive0_n_oe,
    output logic                                     seek_dir_oe,
    output logic                                     track_move_n_oe,
    output logic                                     side_select_oe,
    output logic                                     write_serial_n_oe,
    output logic                                     write_gate_n_oe,
    output logic                                     pad_pullup_en,
    input  wire logic                                track_start_n,
    input  wire logic                                outer_track_n,
    input  wire logic                                write_protect_n,
    input  wire logic                                read_serial_n,
    input  wire logic                                disk_change_n
);
    import fdp_pkg::*;

    // ------------------------------------------------------------
    // Pin conventions
    // ------------------------------------------------------------
    // Every drive-side output but pad_pullup_en is an open-drain enable
    // Enable high: pad sinks current, pin reads low
    // Enable low: pad released, external pull-up wins
    // So each *_oe is the active-high form of its pin
    //
    // Motor and select
    // Motor enable high spins drive 0
    // Select enable high picks drive 0
    // Both follow the core levels one cycle late
    //
    // Head side
    // Side enable high gives a low pin, head side 1
    // Released pin reads high, head side 0
    //
    // Seek
    // Direction enable high gives a low pin, inward motion
    // Direction released gives a high pin, outward motion
    // Direction frozen for the whole seek, never mid-pulse
    // Drives sample direction on the step edge
    // One high phase before the first pulse lets it settle
    // Each pulse moves the head by exactly one track
    //
    // Write path
    // Gate and data both masked by drive select
    // Avoids writing to a drive nobody picked
    // Precompensation is done upstream of this layer
    //
    // Status path
    // Five pins synchronised together, two flops each
    // Status lags the pins by three edges
    // Synchroniser resets to the released level
    // Avoids false status right after reset
    //
    // Pull-ups
    // One config bit disables all five pull-ups
    // Enable kept in step with the config register

    fdp_step_type                 step_state;
    logic [STEP_CNT_W-1:0]        step_cnt;
    logic [TRACK_CNT_W-1:0]       tracks_left;
    logic [4:0]                   sync1;
    logic [4:0]                   sync2;

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    // Clock rate falls back to the low rate at reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_sel_48 <= CLK_SEL_RESET;
        end else if (clk_sel_wr) begin
            clk_sel_48 <= clk_sel_in;
        end
    end

    // Pad configuration and pull-up control
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pad_config_reg <= PAD_CFG_RESET;
            pad_pullup_en  <= 1'b1;
        end else begin
            if (pad_cfg_wr) begin
                pad_config_reg <= pad_cfg_in;
            end
            // One bit kills all five pull-ups together
            pad_pullup_en <= pad_cfg_wr ? !pad_cfg_in[PAD_PULLUP_DIS_BIT]
                                        : !pad_config_reg[PAD_PULLUP_DIS_BIT];
        end
    end

    // ------------------------------------------------------------
    // Drive control outputs
    // ------------------------------------------------------------
    // Enable high pulls the pin low; release lets the pull-up win
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            motor_on_drive0_n_oe <= 1'b0;
            select_drive0_n_oe   <= 1'b0;
            side_select_oe       <= 1'b0;
            write_gate_n_oe      <= 1'b0;
            write_serial_n_oe    <= 1'b0;
        end else begin
            motor_on_drive0_n_oe <= motor_on;
            select_drive0_n_oe   <= drive_select;
            side_select_oe       <= side_one;
            // Writes only reach a selected drive
            write_gate_n_oe      <= write_active && drive_select;
            write_serial_n_oe    <= write_active && drive_select && write_bit;
        end
    end

    // ------------------------------------------------------------
    // Seek: direction then step pulses
    // ------------------------------------------------------------
    // Direction is latched at seek start and frozen while stepping
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            step_state      <= FDP_STEP_IDLE;
            step_cnt        <= '0;
            tracks_left     <= '0;
            seek_dir_oe     <= 1'b0;
            track_move_n_oe <= 1'b0;
            seek_busy       <= 1'b0;
        end else begin
            case (step_state)
                FDP_STEP_IDLE: begin
                    track_move_n_oe <= 1'b0;
                    if (seek_start && seek_tracks != '0) begin
                        seek_dir_oe <= !seek_outward;
                        tracks_left <= seek_tracks;
                        step_cnt    <= STEP_CNT_W'(STEP_HIGH_CYC);
                        seek_busy   <= 1'b1;
                        // Settle direction one high phase before the first pulse
                        step_state  <= FDP_STEP_HIGH;
                    end
                end
                FDP_STEP_LOW: begin
                    if (step_cnt == STEP_CNT_W'(1)) begin
                        track_move_n_oe <= 1'b0;
                        tracks_left     <= tracks_left - TRACK_CNT_W'(1);
                        step_cnt        <= STEP_CNT_W'(STEP_HIGH_CYC);
                        step_state      <= FDP_STEP_HIGH;
                    end else begin
                        step_cnt <= step_cnt - STEP_CNT_W'(1);
                    end
                end
                FDP_STEP_HIGH: begin
                    if (step_cnt != STEP_CNT_W'(1)) begin
                        step_cnt <= step_cnt - STEP_CNT_W'(1);
                    end else if (tracks_left == '0) begin
                        seek_busy  <= 1'b0;
                        step_state <= FDP_STEP_IDLE;
                    end else begin
                        track_move_n_oe <= 1'b1;
                        step_cnt        <= STEP_CNT_W'(STEP_LOW_CYC);
                        step_state      <= FDP_STEP_LOW;
                    end
                end
                default: begin
                    step_state <= FDP_STEP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Drive status inputs
    // ------------------------------------------------------------
    // Two-stage synchroniser; pins are asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
        end else begin
            sync1 <= {disk_change_n, read_serial_n, write_protect_n,
                      outer_track_n, track_start_n};
            sync2 <= sync1;
        end
    end

    // Active-low pins turned into active-high status
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            at_index        <= 1'b0;
            at_outer_track  <= 1'b0;
            write_protected <= 1'b0;
            read_serial     <= 1'b0;
            disk_changed    <= 1'b0;
        end else begin
            at_index        <= !sync2[0];
            at_outer_track  <= !sync2[1];
            write_protected <= !sync2[2];
            read_serial     <= !sync2[3];
            disk_changed    <= !sync2[4];
        end
    end
endmodule : fdp_signal_layer
`default_nettype wire

//--- sim/fdp_checker.sv
// Port-level assertions for the floppy drive signal layer
`timescale 1ns/1ps
`default_nettype none
module fdp_checker (
    input wire logic       sys_clk, resetn, clk_sel_wr, clk_sel_in, motor_on, drive_select,
    input wire logic       side_one, seek_start, seek_outward, write_active, write_bit,
    input wire logic       clk_sel_48, seek_busy, at_index, motor_on_drive0_n_oe,
    input wire logic       select_drive0_n_oe, seek_dir_oe, track_move_n_oe, side_select_oe,
    input wire logic       write_serial_n_oe, write_gate_n_oe, pad_pullup_en, track_start_n,
    input wire logic [7:0] pad_config_reg, seek_tracks
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Step pulse: ten cycles low on the pin, then released
    sequence s_step_low;
        ##9 track_move_n_oe ##1 !track_move_n_oe;
    endsequence
    a_clk_sel_load: assert property (clk_sel_wr |=> clk_sel_48 == $past(clk_sel_in))
        else $error("clock select not loaded");
    a_pullup_tied: assert property (pad_pullup_en == !pad_config_reg[7])
        else $error("pull-up enable disagrees with config");
    a_motor_level: assert property ($past(resetn) |-> motor_on_drive0_n_oe == $past(motor_on))
        else $error("motor pin wrong");
    a_select_level: assert property ($past(resetn) |-> select_drive0_n_oe == $past(drive_select))
        else $error("select pin wrong");
    a_side_level: assert property ($past(resetn) |-> side_select_oe == $past(side_one))
        else $error("side pin wrong");
    a_gate_level: assert property ($past(resetn) |->
        write_gate_n_oe == $past(write_active & drive_select))
        else $error("write gate wrong");
    a_data_level: assert property ($past(resetn) |->
        write_serial_n_oe == $past(write_active & drive_select & write_bit))
        else $error("write data wrong");
    a_seek_dir: assert property (seek_start && !seek_busy && seek_tracks != 8'h00 |=>
        seek_busy && seek_dir_oe == !$past(seek_outward)) else $error("seek direction wrong");
    a_step_width: assert property ($rose(track_move_n_oe) |-> s_step_low)
        else $error("step pulse width wrong");
    a_index_seen: assert property ($fell(track_start_n) |-> ##[1:4] at_index)
        else $error("index not reported");
endmodule : fdp_checker
`default_nettype wire

//--- sim/fdp_drive_model.sv
// Behavioural floppy drive on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module fdp_drive_model (
    input wire logic track_move_n_oe, seek_dir_oe, select_drive0_n_oe, write_serial_n_oe,
    input wire logic index_hole, protect_tab, removed,
    output logic     track_start_n, outer_track_n, write_protect_n, read_serial_n, disk_change_n
);
    int   track = 2;
    logic changed = 1'b1;
    // Head moves on the leading pin edge; a step also clears the change latch
    always @(posedge track_move_n_oe or posedge removed) begin
        if (removed) changed = 1'b1;
        else begin
            track = seek_dir_oe ? track + 1 : track - 1;
            changed = 1'b0;
        end
    end
    assign track_start_n = !index_hole;
    assign outer_track_n = track != 0;
    assign write_protect_n = !protect_tab;
    assign disk_change_n = !changed;
    // Read head loops write data back; unselected line floats to its pull-up
    assign read_serial_n = select_drive0_n_oe ? !write_serial_n_oe : 1'b1;
endmodule : fdp_drive_model
`default_nettype wire

//--- sim/fdp_signal_layer_tb.sv
// Self-checking bench for the floppy drive signal layer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fdp_signal_layer_tb;
    import fdp_pkg::*;
    logic sys_clk = 0, resetn = 0, clk_sel_wr = 0, clk_sel_in = 0, pad_cfg_wr = 0, motor_on = 0;
    logic drive_select = 0, side_one = 0, seek_start = 0, seek_outward = 0, write_active = 0;
    logic write_bit = 0, index_hole = 0, protect_tab = 0, removed = 0;
    logic [7:0] pad_cfg_in = 8'h00, seek_tracks = 8'h00, pad_config_reg;
    logic clk_sel_48, seek_busy, at_index, at_outer_track, write_protected, read_serial;
    logic disk_changed, motor_on_drive0_n_oe, select_drive0_n_oe, seek_dir_oe, track_move_n_oe;
    logic side_select_oe, write_serial_n_oe, write_gate_n_oe, pad_pullup_en;
    logic track_start_n, outer_track_n, write_protect_n, read_serial_n, disk_change_n;
    int   err_total = 0, checks_done = 0;
    always #50 sys_clk = ~sys_clk;
    fdp_signal_layer u_dut (.*);
    fdp_drive_model u_drive (.*);
    task automatic wrap_up;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // One config write of both the rate select and the pad register
    task automatic cfg(input logic s, input logic [7:0] p);
        @(posedge sys_clk);
        {clk_sel_wr, clk_sel_in, pad_cfg_wr, pad_cfg_in} <= {1'b1, s, 1'b1, p};
        @(posedge sys_clk);
        {clk_sel_wr, pad_cfg_wr} <= 2'b00;
        @(negedge sys_clk);
        `CHK(clk_sel_48, s)
        `CHK({pad_config_reg, pad_pullup_en}, {p, !p[7]})
    endtask : cfg
    // Every level combination, with read data looped back by the drive
    task automatic t_levels;
        logic [4:0] v;
        for (int i = 0; i < 32; i++) begin
            v = 5'(i);
            @(posedge sys_clk);
            {motor_on, drive_select, side_one, write_active, write_bit} <= v;
            repeat (5) @(negedge sys_clk);
            `CHK({motor_on_drive0_n_oe, select_drive0_n_oe, side_select_oe}, v[4:2])
            `CHK(write_gate_n_oe, v[3] & v[1])
            `CHK({write_serial_n_oe, read_serial}, {2{&{v[3], v[1], v[0]}}})
        end
    endtask : t_levels
    // Seek, with a refused restart and a flipped direction while busy
    task automatic seek(input logic out, input logic [7:0] n, input logic outer);
        int busy_cyc = 0, steps = 0;
        logic prev = 1'b0;
        @(posedge sys_clk);
        {seek_start, seek_outward, seek_tracks} <= {1'b1, out, n};
        for (int i = 0; i < 900 && (i == 0 || seek_busy); i++) begin
            @(posedge sys_clk);
            {seek_start, seek_outward} <= {i == 5, !out};
            @(negedge sys_clk);
            if (i == 0 && n != 0) `CHK(seek_dir_oe, !out)
            busy_cyc += seek_busy;
            steps += track_move_n_oe & !prev;
            prev = track_move_n_oe;
        end
        repeat (5) @(negedge sys_clk);
        `CHK(busy_cyc, (n != 0) ? 10 + 20 * n : 0)
        `CHK(steps, int'(n))
        `CHK(at_outer_track, outer)
    endtask : seek
    // Index, protect tab and media removal reach the status outputs
    task automatic t_status;
        @(posedge sys_clk);
        {index_hole, protect_tab, removed} <= 3'b111;
        repeat (5) @(negedge sys_clk);
        `CHK({at_index, write_protected, disk_changed}, 3'b111)
        @(posedge sys_clk);
        {index_hole, protect_tab, removed} <= 3'b000;
        repeat (5) @(negedge sys_clk);
        `CHK({at_index, write_protected, disk_changed}, 3'b001)
    endtask : t_status
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK({clk_sel_48, pad_pullup_en, disk_changed}, {CLK_SEL_RESET, 2'b11})
        cfg(1'b1, 8'h80);
        cfg(1'b0, 8'h7F);
        t_levels;
        seek(1'b1, 8'h02, 1'b1);
        seek(1'b1, 8'h01, 1'b0);
        seek(1'b0, 8'h00, 1'b0);
        t_status;
        wrap_up;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #500000;
        err_total++;
        wrap_up;
    end
endmodule : fdp_signal_layer_tb
bind fdp_signal_layer fdp_checker u_chk (.*);
`default_nettype wire
